// ===== rtl/stcr_top.sv
// system time clock recovery: loads, compares and tracks clock samples
// assumes sample strobe comes from the demultiplexer on the same clock,
// pulsed on the cycle the last base byte of the sample is taken
`timescale 1ns/1ns
module stcr_top
  import stcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_sample_valid,
  input wire logic [32:0] i_sample_base,
  input wire logic [8:0] i_sample_ext,
  input wire logic i_sample_is_selected,
  input wire logic i_discontinuity,
  input wire logic i_local_storage_source,
  output logic [32:0] o_presentation_base,
  output logic [32:0] o_local_time_counter_base,
  output logic [8:0] o_local_time_counter_ext,
  output logic o_clk27_tick,
  output logic o_locked,
  output logic signed [47:0] o_error,
  output logic [31:0] o_ctl_word
);
  stcr_state_t state_q;
  logic [32:0] cnt_base;
  logic [8:0] cnt_ext;
  logic [31:0] phase_q;
  logic [32:0] phase_sum;
  logic [31:0] ctl_q;
  logic signed [47:0] integ_q;
  logic signed [47:0] err_q;
  logic [32:0] base_out_q;
  logic locked_q;
  logic tick;
  logic take;
  logic load;
  logic signed [47:0] err_now;
  logic signed [47:0] filt;
  logic signed [47:0] step;
  logic signed [47:0] ctl_tgt;

  // linear count of a time value in 27 MHz units
  function automatic logic [47:0] stcr_lin(input logic [32:0] b, input logic [8:0] e);
    logic [47:0] r;
    r = 48'(b) * 48'(STCR_EXT_MOD) + 48'(e);
    return r;
  endfunction : stcr_lin

  // only samples of the chosen program count
  assign take = i_sample_valid && i_sample_is_selected;
  assign load = take && (state_q == STCR_ACQ);

  // nco standing in for the controlled oscillator
  assign phase_sum = {1'b0, phase_q} + {1'b0, ctl_q};
  assign tick = phase_sum[32];
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_sum[31:0];
    end
  end

  stcr_counter u_counter (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_tick(tick),
    .i_load(load),
    .i_load_base(i_sample_base),
    .i_load_ext(i_sample_ext),
    .o_base(cnt_base),
    .o_ext(cnt_ext)
  );

  // sample minus counter taken at strobe, wrapped to signed range
  always_comb begin
    logic [47:0] range;
    logic [47:0] diff;
    range = stcr_lin(33'h1ffffffff, STCR_EXT_LAST) + 48'h1;
    diff = stcr_lin(i_sample_base, i_sample_ext) - stcr_lin(cnt_base, cnt_ext);
    if (diff[47]) begin
      diff = diff + range;
    end
    if (diff >= (range >> 1)) begin
      diff = diff - range;
    end
    err_now = signed'(diff);
  end

  // acquisition state: acquire, track or free-run
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state_q <= STCR_ACQ;
    end else begin
      case (state_q)
        STCR_ACQ: begin
          if (i_local_storage_source) begin
            state_q <= STCR_FREE;
          end else if (load && !i_discontinuity) begin
            state_q <= STCR_TRACK;
          end
        end
        STCR_TRACK: begin
          if (i_local_storage_source) begin
            state_q <= STCR_FREE;
          end else if (i_discontinuity) begin
            state_q <= STCR_ACQ;
          end
        end
        STCR_FREE: begin
          if (!i_local_storage_source) begin
            state_q <= STCR_ACQ;
          end
        end
        default: state_q <= STCR_ACQ;
      endcase
    end
  end

  // proportional plus integral filter with slew limit
  assign filt = (err_now >>> STCR_KP_SH) + ((integ_q + err_now) >>> STCR_KI_SH);
  always_comb begin
    ctl_tgt = signed'(48'(STCR_NOM_INC)) + filt;
    step = ctl_tgt - signed'(48'(ctl_q));
    if (step > signed'(48'(STCR_SLEW_MAX))) begin
      step = signed'(48'(STCR_SLEW_MAX));
    end else if (step < -signed'(48'(STCR_SLEW_MAX))) begin
      step = -signed'(48'(STCR_SLEW_MAX));
    end
  end

  // control word, integrator and error update per tracked sample
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctl_q <= STCR_NOM_INC;
      integ_q <= '0;
      err_q <= '0;
    end else if (state_q == STCR_FREE || load) begin
      ctl_q <= STCR_NOM_INC;
      integ_q <= '0;
      err_q <= '0;
    end else if (take && state_q == STCR_TRACK && !i_discontinuity) begin
      ctl_q <= 32'(signed'(48'(ctl_q)) + step);
      integ_q <= integ_q + err_now;
      err_q <= err_now;
    end
  end

  // lock flag while the latest tracked sample error is within +/-300
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      locked_q <= 1'b0;
    end else if (state_q != STCR_TRACK) begin
      locked_q <= 1'b0;
    end else if (take) begin
      locked_q <= (err_now < 48'sd300) && (err_now > -48'sd300);
    end
  end

  // registered base for stamp compare
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      base_out_q <= '0;
    end else begin
      base_out_q <= cnt_base;
    end
  end

  assign o_presentation_base = base_out_q;
  assign o_local_time_counter_base = cnt_base;
  assign o_local_time_counter_ext = cnt_ext;
  assign o_clk27_tick = tick;
  assign o_locked = locked_q;
  assign o_error = err_q;
  assign o_ctl_word = ctl_q;

  AST_LOAD_FIRST: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (load && !i_discontinuity && !i_local_storage_source) |=> (cnt_base == $past(i_sample_base) && state_q == STCR_TRACK))
    else $error("first sample not loaded");
  AST_REACQ: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == STCR_TRACK && i_discontinuity && !i_local_storage_source) |=> state_q == STCR_ACQ)
    else $error("no reacquire after discontinuity");
  AST_SEL_ONLY: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == STCR_TRACK && !i_sample_is_selected) |=> ctl_q == $past(ctl_q))
    else $error("unselected sample moved control");
  AST_UNSEL_ERR: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == STCR_TRACK && i_sample_valid && !i_sample_is_selected) |=> err_q == $past(err_q))
    else $error("unselected sample moved error");
  AST_SLEW: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == STCR_TRACK && $past(state_q) == STCR_TRACK) |->
      (ctl_q - $past(ctl_q) <= STCR_SLEW_MAX || $past(ctl_q) - ctl_q <= STCR_SLEW_MAX))
    else $error("control slew too large");
  AST_FREE_NOM: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == STCR_FREE) |=> ctl_q == STCR_NOM_INC)
    else $error("free run not at nominal");
  AST_ERR_CAPTURE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (take && state_q == STCR_TRACK && !i_discontinuity && !i_local_storage_source) |=> err_q == $past(err_now))
    else $error("error not captured");
  AST_BASE_OUT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ##1 o_presentation_base == $past(cnt_base))
    else $error("presentation base stale");
  AST_ERR_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (take && i_sample_base == 33'h0 && cnt_base == 33'h1ffffffff && i_sample_ext == cnt_ext) |-> err_now == 48'sd300)
    else $error("wrap gave large error");
endmodule : stcr_top

// ===== rtl/stcr_pkg.sv
// package for the system time clock recovery block
// assumes a single core clock domain at 250 MHz driving the whole block
package stcr_pkg;
  localparam int unsigned STCR_BASE_W = 33; // 90 kHz base counter width
  localparam int unsigned STCR_EXT_W = 9; // extension field width
  localparam logic [8:0] STCR_EXT_MOD = 9'h12c; // extension modulus, 300
  localparam logic [8:0] STCR_EXT_LAST = 9'h12b; // last extension value, 299
  localparam int unsigned STCR_ERR_W = 48; // linear error width in 27 MHz units
  localparam int unsigned STCR_CTL_W = 32; // oscillator control word width
  // 27 MHz nco increment at 250 MHz core: 27/250 * 2^32
  localparam logic [31:0] STCR_NOM_INC = 32'h1ba5e354;
  localparam int unsigned STCR_KP_SH = 8; // proportional gain shift
  localparam int unsigned STCR_KI_SH = 16; // integral gain shift
  localparam logic [31:0] STCR_SLEW_MAX = 32'h00001000; // max control step per sample
  localparam logic [31:0] STCR_CTL_SPAN = 32'h00800000; // offset span from nominal; unused, the control word is not clamped to it
  localparam int unsigned STCR_CORE_MHZ = 250;
  localparam int unsigned STCR_TS_GAP_MS = 100;
  localparam int unsigned STCR_PS_GAP_MS = 700;
  typedef enum logic [1:0] {STCR_ACQ, STCR_TRACK, STCR_FREE} stcr_state_t;
endpackage : stcr_pkg

// ===== rtl/stcr_counter.sv
// local time counter: extension modulo 300 and 33-bit 90 kHz base
// assumes tick is a one-cycle pulse per recovered 27 MHz cycle
`timescale 1ns/1ns
module stcr_counter
  import stcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic [32:0] i_load_base,
  input wire logic [8:0] i_load_ext,
  output logic [32:0] o_base,
  output logic [8:0] o_ext
);
  logic [32:0] base_q;
  logic [8:0] ext_q;

  // load wins over tick; ext wraps into base
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      base_q <= '0;
      ext_q <= '0;
    end else if (i_load) begin
      base_q <= i_load_base;
      ext_q <= i_load_ext;
    end else if (i_tick) begin
      if (ext_q == STCR_EXT_LAST) begin
        ext_q <= '0;
        base_q <= base_q + 33'h1;
      end else begin
        ext_q <= ext_q + 9'h1;
      end
    end
  end

  assign o_base = base_q;
  assign o_ext = ext_q;

  AST_EXT_RANGE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) ext_q < STCR_EXT_MOD)
    else $error("extension out of range");
  AST_BASE_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_tick && !i_load && ext_q == STCR_EXT_LAST) |=> (ext_q == 9'h0 && base_q == $past(base_q) + 33'h1))
    else $error("base did not advance on extension wrap");
endmodule : stcr_counter

// ===== sim/stcr_demux_model.sv
// stream demultiplexer model: hands clock samples to the recovery block
// assumes the bench calls send at a falling edge of the core clock
`timescale 1ns/1ns
module stcr_demux_model (
  input wire logic i_core_clk,
  output logic o_valid,
  output logic [32:0] o_base,
  output logic [8:0] o_ext,
  output logic o_selected,
  output logic o_disc
);
  // idle lines start quiet
  initial begin
    o_valid = 1'b0;
    o_base = '0;
    o_ext = '0;
    o_selected = 1'b0;
    o_disc = 1'b0;
  end
  // one-cycle strobe at the last base byte, then junk so no stale sample shows
  task automatic send(input logic [32:0] b, input logic [8:0] e, input logic sel, input logic dis);
    o_valid = 1'b1;
    o_base = b;
    o_ext = e;
    o_selected = sel;
    o_disc = dis;
    @(negedge i_core_clk);
    o_valid = 1'b0;
    o_base = ~b;
    o_ext = ~e;
    o_selected = ~sel;
    o_disc = 1'b0;
  endtask : send
endmodule : stcr_demux_model

// ===== sim/tb_top.sv
// bench for the clock recovery block: loads, tracks, refusals, wrap, free-run
// assumes samples come from the demultiplexer model, all driving at falling edges
`timescale 1ns/1ns
module tb_top;
  import stcr_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_local_storage_source = 1'b0;
  logic v, sel, dis, tick, lock;
  logic [32:0] sb, pb, cb;
  logic [32:0] xb;
  logic [31:0] ctl0;
  logic [8:0] se, ce;
  logic signed [47:0] err;
  logic [31:0] ctl;
  logic [63:0] m = 64'h200000000 * 64'd300;
  int n_errors = 0;
  int n_tests = 0;
  int k;
  // 250 MHz core clock
  always #2 i_core_clk = ~i_core_clk;
  stcr_demux_model dmx (.i_core_clk(i_core_clk), .o_valid(v), .o_base(sb), .o_ext(se),
    .o_selected(sel), .o_disc(dis));
  stcr_top uut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_sample_valid(v),
    .i_sample_base(sb), .i_sample_ext(se), .i_sample_is_selected(sel), .i_discontinuity(dis),
    .i_local_storage_source(i_local_storage_source), .o_presentation_base(pb),
    .o_local_time_counter_base(cb), .o_local_time_counter_ext(ce), .o_clk27_tick(tick),
    .o_locked(lock), .o_error(err), .o_ctl_word(ctl));
  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // counter value in 27 MHz units
  function automatic logic [63:0] lin(input logic [32:0] b, input logic [8:0] e);
    return {31'h0, b} * 64'd300 + {55'h0, e};
  endfunction : lin
  // difference folded into the signed range of the counter span
  function automatic logic [47:0] werr(input logic [63:0] s, input logic [63:0] c);
    logic [63:0] d;
    d = (s + m - c) % m;
    return (d >= m / 2) ? 48'(d - m) : 48'(d);
  endfunction : werr
  // sample at counter plus offset; taken ones must update error, others leave it
  task automatic hit(input longint off, input logic sl, input logic ds, input logic taken);
    logic [63:0] c, s;
    logic [47:0] w, e0;
    logic [31:0] f0, dc;
    @(negedge i_core_clk); // idle edge keeps back-to-back strobes apart
    c = lin(cb, ce);
    s = (c + m + 64'(off)) % m;
    w = werr(s, c);
    e0 = err;
    f0 = ctl;
    dmx.send(33'(s / 300), 9'(s % 300), sl, ds);
    if (taken) begin
      chk(err[47:0], w);
      chk(lock, ($signed(w) < 300 && $signed(w) > -300));
      dc = ctl - f0;
      chk(($signed(dc) <= 32'sh1000 && $signed(dc) >= -32'sh1000), 1);
    end else begin
      chk(err[47:0], e0);
      chk(lin(cb, ce) == s, 0);
    end
  endtask : hit
  // load a fresh time base and check it lands in the counter
  task automatic load(input logic [32:0] b, input logic [8:0] e);
    @(negedge i_core_clk); // idle edge keeps back-to-back strobes apart
    dmx.send(b, e, 1'b1, 1'b0);
    chk(cb, b);
    chk(ce, e);
  endtask : load
  // print counts and the verdict, then stop
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // hang guard
  initial begin
    #380000;
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(70582));
    repeat (16) @(negedge i_core_clk);
    chk({cb, ce, err[15:0], lock}, 0);
    chk(ctl, STCR_NOM_INC);
    i_reset_n = 1'b1;
    k = 0;
    // nominal tick rate and counter advance with extension wrap
    repeat (5000) begin
      k += int'(tick);
      @(negedge i_core_clk);
    end
    chk((k >= 539 && k <= 541), 1);
    chk(lin(cb, ce), 64'(k));
    xb = 33'({$urandom, $urandom});
    load(xb, 9'($urandom % 300));
    @(negedge i_core_clk);
    chk(pb, xb);
    // random tracking, some back to back
    for (int i = 0; i < 16; i++) begin
      hit((i % 3 == 0) ? longint'($urandom % 500) - 250 : longint'($urandom % 100000) - 50000, 1, 0, 1);
      repeat ($urandom % 3 * 7) @(negedge i_core_clk);
    end
    // huge error must be clamped to one slew step
    ctl0 = ctl;
    hit(64'd4000000000, 1, 0, 1);
    chk(32'(ctl - ctl0), STCR_SLEW_MAX);
    hit(70000, 0, 0, 0);
    hit(90000, 1, 1, 0);
    load(33'h1ffffffff, 9'h12b);
    repeat (3) @(negedge i_core_clk);
    hit(400, 1, 0, 1);
    // sample exactly one base step (300 extension units) past the counter, across a base wrap
    hit(5000, 1, 1, 0);
    load(33'h1ffffffff, 9'h000);
    hit(300, 1, 0, 1);
    i_local_storage_source = 1'b1;
    @(negedge i_core_clk);
    hit(123456, 1, 0, 0);
    chk(ctl, STCR_NOM_INC);
    give_verdict();
  end
endmodule : tb_top
